// ===== ntmrs_pkg.sv
// Purpose: shared constants for the network time mirror and rtc sync block
// Assumes: 200 MHz aclk, AXI4-Lite register access with 32-bit data
// Notes: Behaviour list below; tags mark where each item is carried out
//
// Behaviour
// (R1) with sync enabled, request server time once every ten minutes
// (R2) each new time reading adds one to the time update counter
// (R3) the same update refreshes all seven calendar mirror words
// (R4) controller copies mirror words to staging words when counter changes
// (R5) controller then saves the counter value for the next compare
// (R6) commit control bit follows compare result, dropping once copy matches
// (R7) falling commit control bit loads the seven staging words into the rtc
// (R8) periodic update plus commit keep rtc within one second of network time
// (R9) disabled or unanswered sync leaves counter and mirror words unchanged
package ntmrs_pkg;
    // register byte offsets
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h04;
    localparam logic [7:0] REG_MASK = 8'h08;
    localparam logic [7:0] REG_COUNT = 8'h0C;
    localparam logic [7:0] REG_CAL_BASE = 8'h10;
    localparam logic [7:0] REG_STAGE_BASE = 8'h30;
    localparam int CAL_WORDS = 7;
    localparam int WORD_W = 16;
    localparam logic [7:0] CAL_SPAN = 8'h1C;
    // control and status fields
    localparam int CTRL_SYNC_EN = 0;
    localparam int CTRL_COMMIT = 1;
    localparam int CTRL_W = 2;
    localparam int ST_UPDATE = 0;
    localparam int ST_TIMEOUT = 1;
    localparam int ST_COMMIT = 2;
    localparam int ST_W = 3;
    localparam logic [CTRL_W-1:0] CTRL_RESET = 2'h0;
    localparam logic [WORD_W-1:0] COUNT_RESET = 16'h0000;
    // bus responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // timing
    localparam longint CLK_HZ = 200_000_000;
    localparam longint FETCH_PERIOD_MIN = 10;
    localparam longint REPLY_TIMEOUT_MS = 500;
    localparam logic [39:0] FETCH_CYCLES_DEF = 40'(FETCH_PERIOD_MIN * 60 * CLK_HZ);
    localparam logic [39:0] REPLY_CYCLES_DEF = 40'(REPLY_TIMEOUT_MS * CLK_HZ / 1000);
    typedef enum logic {NTMRS_IDLE, NTMRS_WAIT} ntmrs_state_t;
endpackage

// ===== ntmrs_reg_if.sv
// Purpose: simple register access path between bus slave and register file
// Assumes: single clock, rd_data and errors answered in the same cycle
// Notes: wr_en and rd_en are single-cycle strobes
interface ntmrs_reg_if;
    logic wr_en;
    logic [7:0] wr_addr;
    logic [31:0] wr_data;
    logic [3:0] wr_strb;
    logic wr_err;
    logic rd_en;
    logic [7:0] rd_addr;
    logic [31:0] rd_data;
    logic rd_err;
    modport bus_side (output wr_en, wr_addr, wr_data, wr_strb, rd_en, rd_addr,
                      input wr_err, rd_data, rd_err);
    modport reg_side (input wr_en, wr_addr, wr_data, wr_strb, rd_en, rd_addr,
                      output wr_err, rd_data, rd_err);
endinterface

// ===== ntmrs_axil_slave.sv
// Purpose: AXI4-Lite slave front end feeding the register interface
// Assumes: one write and one read outstanding at most
// Notes: address and data may arrive in either order; all AXI outputs registered, rif strobes and read address combinational
module ntmrs_axil_slave
    import ntmrs_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [7:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    ntmrs_reg_if.bus_side rif
);
    logic aw_held, w_held;
    logic next_aw_held, next_w_held, next_awready, next_wready, next_arready;
    logic [7:0] aw_addr, next_aw_addr;
    logic [31:0] w_data, next_w_data, next_rdata;
    logic [3:0] w_strb, next_w_strb;
    logic next_bvalid, next_rvalid;
    logic [1:0] next_bresp, next_rresp;
    logic do_wr;

    // write fires once both halves are held and the last response is gone
    assign do_wr = aw_held && w_held && !bvalid;
    assign rif.wr_en = do_wr;
    assign rif.wr_addr = aw_addr;
    assign rif.wr_data = w_data;
    assign rif.wr_strb = w_strb;
    assign rif.rd_en = arvalid && arready;
    assign rif.rd_addr = araddr;

    // handshake bookkeeping; readies are precomputed so they leave flops
    always_comb begin
        next_aw_held = aw_held;
        next_aw_addr = aw_addr;
        next_w_held = w_held;
        next_w_data = w_data;
        next_w_strb = w_strb;
        next_bvalid = bvalid;
        next_bresp = bresp;
        next_rvalid = rvalid;
        next_rdata = rdata;
        next_rresp = rresp;
        if (awvalid && awready) begin
            next_aw_held = 1'b1;
            next_aw_addr = awaddr;
        end
        if (wvalid && wready) begin
            next_w_held = 1'b1;
            next_w_data = wdata;
            next_w_strb = wstrb;
        end
        if (bvalid && bready) begin
            next_bvalid = 1'b0;
        end
        if (do_wr) begin
            next_aw_held = 1'b0;
            next_w_held = 1'b0;
            next_bvalid = 1'b1;
            next_bresp = rif.wr_err ? RESP_SLVERR : RESP_OKAY;
        end
        if (rvalid && rready) begin
            next_rvalid = 1'b0;
        end
        if (arvalid && arready) begin
            next_rvalid = 1'b1;
            next_rdata = rif.rd_data;
            next_rresp = rif.rd_err ? RESP_SLVERR : RESP_OKAY;
        end
        next_awready = !next_aw_held && !next_bvalid;
        next_wready = !next_w_held && !next_bvalid;
        next_arready = !next_rvalid;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held <= 1'b0;
            aw_addr <= 8'h00;
            w_held <= 1'b0;
            w_data <= 32'h0000_0000;
            w_strb <= 4'h0;
            bvalid <= 1'b0;
            bresp <= RESP_OKAY;
            rvalid <= 1'b0;
            rdata <= 32'h0000_0000;
            rresp <= RESP_OKAY;
            awready <= 1'b0;
            wready <= 1'b0;
            arready <= 1'b0;
        end else begin
            aw_held <= next_aw_held;
            aw_addr <= next_aw_addr;
            w_held <= next_w_held;
            w_data <= next_w_data;
            w_strb <= next_w_strb;
            bvalid <= next_bvalid;
            bresp <= next_bresp;
            rvalid <= next_rvalid;
            rdata <= next_rdata;
            rresp <= next_rresp;
            awready <= next_awready;
            wready <= next_wready;
            arready <= next_arready;
        end
    end
endmodule

// ===== ntmrs_time_sync.sv
// Purpose: network time fetch, calendar mirror, rtc staging and commit
// Assumes: reply_valid is a one-cycle strobe with reply_words stable in it
// Notes: registers over AXI4-Lite; irq is a level from a flop
//
// Design decisions made here: the register addresses and the AXI4-Lite register port.
module ntmrs_time_sync
    import ntmrs_pkg::*;
#(
    parameter logic [39:0] FETCH_CYCLES = FETCH_CYCLES_DEF,
    parameter logic [39:0] REPLY_CYCLES = REPLY_CYCLES_DEF
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic time_req,
    input wire logic reply_valid,
    input wire logic [CAL_WORDS-1:0][WORD_W-1:0] reply_words,
    output logic rtc_load,
    output logic [CAL_WORDS-1:0][WORD_W-1:0] rtc_time,
    output logic irq
);
    ntmrs_reg_if rif();

    ntmrs_axil_slave u_slave (
        .aclk(aclk),
        .aresetn(aresetn),
        .awaddr(s_axi_awaddr),
        .awvalid(s_axi_awvalid),
        .awready(s_axi_awready),
        .wdata(s_axi_wdata),
        .wstrb(s_axi_wstrb),
        .wvalid(s_axi_wvalid),
        .wready(s_axi_wready),
        .bresp(s_axi_bresp),
        .bvalid(s_axi_bvalid),
        .bready(s_axi_bready),
        .araddr(s_axi_araddr),
        .arvalid(s_axi_arvalid),
        .arready(s_axi_arready),
        .rdata(s_axi_rdata),
        .rresp(s_axi_rresp),
        .rvalid(s_axi_rvalid),
        .rready(s_axi_rready),
        .rif(rif)
    );

    ntmrs_state_t state, next_state;
    logic [39:0] timer, next_timer, wait_cnt, next_wait_cnt;
    logic [CTRL_W-1:0] ctrl, next_ctrl;
    logic [ST_W-1:0] status, next_status, mask, next_mask, events;
    logic [WORD_W-1:0] counter, next_counter;
    logic [CAL_WORDS-1:0][WORD_W-1:0] mirror, next_mirror, staging, next_staging;
    logic [CAL_WORDS-1:0][WORD_W-1:0] next_rtc_time;
    logic next_time_req, next_rtc_load, next_irq, commit_prev, sync_en, commit_fall;

    assign sync_en = ctrl[CTRL_SYNC_EN];
    // commit edge seen on the stored bit, so back-to-back writes still count
    assign commit_fall = commit_prev && !ctrl[CTRL_COMMIT];

    function automatic logic [WORD_W-1:0] merge16(input logic [WORD_W-1:0] old,
                                                  input logic [31:0] d,
                                                  input logic [3:0] s);
        merge16 = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
    endfunction

    function automatic logic in_win(input logic [7:0] a, input logic [7:0] base);
        in_win = (a >= base) && (a < base + CAL_SPAN) && (a[1:0] == 2'h0);
    endfunction

    // read decode, answered in the handshake cycle
    always_comb begin
        logic [7:0] off;
        off = 8'h00;
        rif.rd_data = 32'h0000_0000;
        rif.rd_err = 1'b0;
        if (in_win(rif.rd_addr, REG_CAL_BASE)) begin
            off = rif.rd_addr - REG_CAL_BASE;
            rif.rd_data = {16'h0000, mirror[off[4:2]]};
        end else if (in_win(rif.rd_addr, REG_STAGE_BASE)) begin
            off = rif.rd_addr - REG_STAGE_BASE;
            rif.rd_data = {16'h0000, staging[off[4:2]]};
        end else begin
            unique case (rif.rd_addr)
                REG_CTRL: rif.rd_data = {30'h0000_0000, ctrl};
                REG_STATUS: rif.rd_data = {29'h0000_0000, status};
                REG_MASK: rif.rd_data = {29'h0000_0000, mask};
                REG_COUNT: rif.rd_data = {16'h0000, counter};
                default: rif.rd_err = 1'b1;
            endcase
        end
    end

    // fetch sequencer: period timer, reply wait, mirror refresh
    always_comb begin
        next_state = state;
        next_timer = timer;
        next_wait_cnt = wait_cnt;
        next_time_req = 1'b0;
        next_counter = counter;
        next_mirror = mirror;
        events = '0;
        if (!sync_en) begin
            next_state = NTMRS_IDLE; // R9
            next_timer = 40'h0;
            next_wait_cnt = 40'h0;
        end else begin
            // period runs regardless of the wait, keeping a fixed cadence
            next_timer = (timer == FETCH_CYCLES - 40'h1) ? 40'h0 : timer + 40'h1; // R1
            unique case (state)
                NTMRS_IDLE: begin
                    if (timer == FETCH_CYCLES - 40'h1) begin
                        next_time_req = 1'b1; // R1
                        next_state = NTMRS_WAIT;
                        next_wait_cnt = 40'h0;
                    end
                end
                NTMRS_WAIT: begin
                    if (reply_valid) begin
                        next_counter = counter + 16'h0001; // R2
                        next_mirror = reply_words; // R3
                        events[ST_UPDATE] = 1'b1;
                        next_state = NTMRS_IDLE;
                    end else if (wait_cnt == REPLY_CYCLES - 40'h1) begin
                        // stale replies are dropped rather than mirrored late
                        events[ST_TIMEOUT] = 1'b1; // R8 R9
                        next_state = NTMRS_IDLE;
                    end else begin
                        next_wait_cnt = wait_cnt + 40'h1;
                    end
                end
            endcase
        end
    end

    // software registers, commit edge and interrupt
    always_comb begin
        logic [7:0] off;
        off = 8'h00;
        next_ctrl = ctrl;
        next_mask = mask;
        next_staging = staging;
        rif.wr_err = 1'b0;
        next_rtc_load = commit_fall; // R7
        next_rtc_time = commit_fall ? staging : rtc_time; // R7
        next_status = status;
        if (rif.wr_en) begin
            if (in_win(rif.wr_addr, REG_STAGE_BASE)) begin
                off = rif.wr_addr - REG_STAGE_BASE;
                for (int i = 0; i < CAL_WORDS; i++) begin
                    if (off[4:2] == 3'(i)) begin
                        next_staging[i] = merge16(staging[i], rif.wr_data, rif.wr_strb);
                    end
                end
            end else begin
                unique case (rif.wr_addr)
                    REG_CTRL: if (rif.wr_strb[0]) next_ctrl = rif.wr_data[CTRL_W-1:0];
                    REG_STATUS: if (rif.wr_strb[0]) next_status = status & ~rif.wr_data[ST_W-1:0];
                    REG_MASK: if (rif.wr_strb[0]) next_mask = rif.wr_data[ST_W-1:0];
                    REG_COUNT: rif.wr_err = 1'b1;
                    default: rif.wr_err = !in_win(rif.wr_addr, REG_CAL_BASE);
                endcase
            end
        end
        // a new event beats a clear in the same cycle
        next_status = next_status | events | {commit_fall, 2'h0};
        next_irq = |(next_status & next_mask);
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state <= NTMRS_IDLE;
            timer <= 40'h0;
            wait_cnt <= 40'h0;
            time_req <= 1'b0;
            counter <= COUNT_RESET;
            mirror <= '0;
            ctrl <= CTRL_RESET;
            mask <= '0;
            status <= '0;
            staging <= '0;
            commit_prev <= 1'b0;
            rtc_load <= 1'b0;
            rtc_time <= '0;
            irq <= 1'b0;
        end else begin
            state <= next_state;
            timer <= next_timer;
            wait_cnt <= next_wait_cnt;
            time_req <= next_time_req;
            counter <= next_counter;
            mirror <= next_mirror;
            ctrl <= next_ctrl;
            mask <= next_mask;
            status <= next_status;
            staging <= next_staging;
            commit_prev <= ctrl[CTRL_COMMIT];
            rtc_load <= next_rtc_load;
            rtc_time <= next_rtc_time;
            irq <= next_irq;
        end
    end

    chk_req_on_period: assert property (@(posedge aclk) disable iff (!aresetn) // R1
        time_req |-> $past(timer) == FETCH_CYCLES - 40'h1 && state == NTMRS_WAIT)
        else $error("time request off the fetch period");
    chk_count_bump: assert property (@(posedge aclk) disable iff (!aresetn) // R2
        (sync_en && state == NTMRS_WAIT && reply_valid) |=> counter == $past(counter) + 16'h0001)
        else $error("counter not bumped on reply");
    chk_mirror_fresh: assert property (@(posedge aclk) disable iff (!aresetn) // R3
        (sync_en && state == NTMRS_WAIT && reply_valid) |=> mirror == $past(reply_words))
        else $error("mirror words not refreshed");
    chk_commit_load: assert property (@(posedge aclk) disable iff (!aresetn) // R7
        $fell(ctrl[CTRL_COMMIT]) |=> rtc_load && rtc_time == $past(staging) ##1 !rtc_load)
        else $error("rtc not loaded on commit fall");
    chk_wait_bound: assert property (@(posedge aclk) disable iff (!aresetn) // R8
        state == NTMRS_WAIT |-> wait_cnt < REPLY_CYCLES)
        else $error("reply wait overran its bound");
    chk_idle_frozen: assert property (@(posedge aclk) disable iff (!aresetn) // R9
        (!sync_en || state == NTMRS_IDLE) |=> $stable(counter) && $stable(mirror))
        else $error("mirror changed without a reply");
endmodule

// ===== ntmrs_server_model.sv
// Purpose: behavioural network time server answering time requests
// Assumes: time_req is a one-cycle pulse from the block
// Notes: mute ignores new requests so the block's reply timeout can run out
module ntmrs_server_model
    import ntmrs_pkg::*;
#(
    parameter int DELAY = 3
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic mute,
    input wire logic time_req,
    output logic reply_valid,
    output logic [CAL_WORDS-1:0][WORD_W-1:0] reply_words,
    output int sent
);
    int wait_n;

    // one reply DELAY edges after a request; words toggle when not valid
    always @(posedge aclk) begin
        // valid is written once per edge so the strobe never glitches
        reply_valid <= aresetn && (wait_n == 1);
        if (!aresetn) begin
            wait_n <= 0;
            sent <= 0;
            reply_words <= '0;
        end else if (wait_n == 1) begin
            sent <= sent + 1;
            wait_n <= 0;
            for (int i = 0; i < CAL_WORDS; i++) begin
                reply_words[i] <= {4'(i), 12'(sent + 1)};
            end
        end else begin
            // stale words must never look like a fresh reading
            reply_words <= ~reply_words;
            if (wait_n > 1) begin
                wait_n <= wait_n - 1;
            end else if (time_req && !mute) begin
                wait_n <= DELAY;
            end
        end
    end
endmodule

// ===== ntmrs_time_sync_bench.sv
// Purpose: self-checking bench for the time mirror and rtc commit block
// Assumes: fetch period shortened to 50 cycles, reply timeout to 20
// Notes: the scan tasks play the controller that copies and commits time
module ntmrs_time_sync_bench;
    import ntmrs_pkg::*;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int FETCH = 50;
    localparam int REPLY = 20;
    logic aclk, aresetn, mute;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic time_req, reply_valid, rtc_load, irq;
    logic [CAL_WORDS-1:0][WORD_W-1:0] reply_words, rtc_time;
    int sent, cyc, req_last, req_gap, req_n, load_n, mismatches, tests_run;

    ntmrs_time_sync #(.FETCH_CYCLES(40'd50), .REPLY_CYCLES(40'd20)) ntmrs_time_sync_inst (
        .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
        .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready), .time_req(time_req), .reply_valid(reply_valid),
        .reply_words(reply_words), .rtc_load(rtc_load), .rtc_time(rtc_time), .irq(irq));

    ntmrs_server_model ntmrs_server_model_inst (.aclk(aclk), .aresetn(aresetn),
        .mute(mute), .time_req(time_req), .reply_valid(reply_valid),
        .reply_words(reply_words), .sent(sent));

    // clock, 5 ns period
    initial begin
        aclk = 1'b0;
        forever #2.5 aclk = ~aclk;
    end

    // request spacing and rtc load pulses seen at the pins
    always @(posedge aclk) begin
        cyc++;
        if (time_req === 1'b1) begin
            req_gap = cyc - req_last;
            req_last = cyc;
            req_n++;
        end
        if (rtc_load === 1'b1) begin
            load_n++;
        end
    end

    function automatic logic [15:0] tw(input int n, input int i);
        return {4'(i), 12'(n)};
    endfunction

    task automatic check_val(input string what, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic end_of_test;
        $display("comparisons %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // address and data offered together, each released once taken
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        logic aw_ok = 1'b0;
        logic w_ok = 1'b0;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (!(aw_ok && w_ok)) begin
            @(posedge aclk);
            if (!aw_ok && s_axi_awready === 1'b1) begin
                aw_ok = 1'b1;
                s_axi_awvalid <= 1'b0;
            end
            if (!w_ok && s_axi_wready === 1'b1) begin
                w_ok = 1'b1;
                s_axi_wvalid <= 1'b0;
            end
        end
        while (s_axi_bvalid !== 1'b1) @(posedge aclk);
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask

    task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        logic ar_ok = 1'b0;
        logic got = 1'b0;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        while (!got) begin
            @(posedge aclk);
            if (!ar_ok && s_axi_arready === 1'b1) begin
                ar_ok = 1'b1;
                s_axi_arvalid <= 1'b0;
            end else if (ar_ok && s_axi_rvalid === 1'b1) begin
                got = 1'b1;
                d = s_axi_rdata;
                r = s_axi_rresp;
                s_axi_rready <= 1'b0;
            end
        end
    endtask

    task automatic wr_chk(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        logic [1:0] r;
        axi_wr(a, d, r);
        check_val("write response", {30'h0, er}, {30'h0, r});
    endtask

    task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] e,
                          input logic [1:0] er);
        logic [31:0] d;
        logic [1:0] r;
        axi_rd(a, d, r);
        check_val(what, e, d);
        check_val("read response", {30'h0, er}, {30'h0, r});
    endtask

    // reset values, an unmapped place and the read-only places
    task automatic t_reset_values;
        rd_chk("ctrl", REG_CTRL, 32'h0000_0000, RESP_OKAY);
        rd_chk("status", REG_STATUS, 32'h0000_0000, RESP_OKAY);
        rd_chk("mask", REG_MASK, 32'h0000_0000, RESP_OKAY);
        rd_chk("stage0", REG_STAGE_BASE, 32'h0000_0000, RESP_OKAY);
        rd_chk("unmapped", 8'h50, 32'h0000_0000, RESP_SLVERR);
        wr_chk(REG_COUNT, 32'h0000_0005, RESP_SLVERR);
        wr_chk(REG_CAL_BASE, 32'h0000_abcd, RESP_OKAY);
        rd_chk("counter", REG_COUNT, 32'h0000_0000, RESP_OKAY);
        rd_chk("mirror0", REG_CAL_BASE, 32'h0000_0000, RESP_OKAY);
    endtask

    // no request and no update while sync is off
    task automatic t_disabled;
        int n0 = req_n;
        repeat (2 * FETCH + 20) @(posedge aclk);
        check_val("requests while off", 32'(n0), 32'(req_n));
        rd_chk("counter", REG_COUNT, 32'(sent), RESP_OKAY);
    endtask

    // periodic fetch, counter bump, mirror refresh, interrupt
    task automatic t_fetch_update;
        wr_chk(REG_MASK, 32'h0000_0007, RESP_OKAY);
        wr_chk(REG_CTRL, 32'h0000_0001, RESP_OKAY);
        while (req_n < 2) @(posedge aclk);
        check_val("fetch spacing", 32'(FETCH), 32'(req_gap));
        repeat (8) @(posedge aclk);
        // stop fetching so the mirror holds still while read
        wr_chk(REG_CTRL, 32'h0000_0000, RESP_OKAY);
        check_val("irq on update", 32'h1, {31'h0, irq});
        rd_chk("status", REG_STATUS, 32'h0000_0001, RESP_OKAY);
        rd_chk("counter", REG_COUNT, 32'h0000_0002, RESP_OKAY);
        for (int i = 0; i < CAL_WORDS; i++) begin
            rd_chk("mirror", REG_CAL_BASE + 8'(4 * i), {16'h0, tw(sent, i)}, RESP_OKAY);
        end
        wr_chk(REG_STATUS, 32'h0000_0001, RESP_OKAY);
        repeat (2) @(posedge aclk);
        check_val("irq after clear", 32'h0, {31'h0, irq});
    endtask

    // request with no answer: timeout flagged, nothing mirrored
    task automatic t_no_reply;
        int n0 = req_n;
        mute <= 1'b1;
        wr_chk(REG_CTRL, 32'h0000_0001, RESP_OKAY);
        while (req_n == n0) @(posedge aclk);
        repeat (REPLY + 6) @(posedge aclk);
        wr_chk(REG_CTRL, 32'h0000_0000, RESP_OKAY);
        rd_chk("status", REG_STATUS, 32'h0000_0002, RESP_OKAY);
        check_val("irq on timeout", 32'h1, {31'h0, irq});
        rd_chk("counter", REG_COUNT, 32'(sent), RESP_OKAY);
        mute <= 1'b0;
        wr_chk(REG_STATUS, 32'h0000_0007, RESP_OKAY);
        repeat (2) @(posedge aclk);
        check_val("irq after clear", 32'h0, {31'h0, irq});
    endtask

    // two controller scans: copy on counter change, then commit on the fall
    task automatic t_commit;
        logic [31:0] cnt, w;
        logic [1:0] r;
        int last_seen_counter_copy = 0;
        int n0 = load_n;
        axi_rd(REG_COUNT, cnt, r);
        if (cnt != 32'(last_seen_counter_copy)) begin
            for (int i = 0; i < CAL_WORDS; i++) begin
                axi_rd(REG_CAL_BASE + 8'(4 * i), w, r);
                wr_chk(REG_STAGE_BASE + 8'(4 * i), {16'hffff, w[15:0]}, RESP_OKAY);
            end
            wr_chk(REG_CTRL, 32'h0000_0002, RESP_OKAY);
            last_seen_counter_copy = int'(cnt);
        end
        repeat (3) @(posedge aclk);
        check_val("load before fall", 32'(n0), 32'(load_n));
        rd_chk("stage6", REG_STAGE_BASE + 8'h18, {16'h0, tw(sent, 6)}, RESP_OKAY);
        axi_rd(REG_COUNT, cnt, r);
        check_val("saved copy", cnt, 32'(last_seen_counter_copy));
        wr_chk(REG_CTRL, 32'h0000_0000, RESP_OKAY);
        repeat (3) @(posedge aclk);
        check_val("rtc loads", 32'(n0 + 1), 32'(load_n));
        for (int i = 0; i < CAL_WORDS; i++) begin
            check_val("rtc time", {16'h0, tw(sent, i)}, {16'h0, rtc_time[i]});
        end
        rd_chk("status", REG_STATUS, 32'h0000_0004, RESP_OKAY);
    endtask

    // hang guard, well beyond the expected run length
    initial begin
        repeat (6000) @(posedge aclk);
        mismatches++;
        end_of_test();
    end

    initial begin
        aresetn = 1'b0;
        mute = 1'b0;
        s_axi_awaddr = 8'h00;
        s_axi_araddr = 8'h00;
        s_axi_wdata = 32'h0000_0000;
        s_axi_wstrb = 4'hf;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (2) @(posedge aclk);
        t_reset_values();
        t_disabled();
        t_fetch_update();
        t_disabled();
        t_no_reply();
        t_commit();
        end_of_test();
    end
endmodule
